/* ssr_pkg.sv */
// Constants for the synthesizer serial register host controller.
// Assumes a single 20 MHz clock and 32-bit AXI4-Lite data.
`default_nettype none
package ssr_pkg;
  // Device register-select codes
  localparam logic [3:0] SSR_CODE_INT = 4'h0;
  localparam logic [3:0] SSR_CODE_FRAC = 4'h1;
  localparam logic [3:0] SSR_CODE_TMO = 4'h9;
  localparam logic [3:0] SSR_CODE_ADC = 4'hA;
  localparam logic [3:0] SSR_CODE_FIX = 4'hB;
  localparam logic [3:0] SSR_CODE_RSY = 4'hC;
  // Device word field positions
  localparam int SSR_CAL_BIT = 21;
  localparam int SSR_PRE_BIT = 20;
  localparam int SSR_DATA_LSB = 4;
  // Fixed-one masks of the reserved words
  localparam logic [31:0] SSR_ADC_ONES = 32'h00C0_0000;
  localparam logic [31:0] SSR_FIX_WORD = 32'h0061_300B;
  localparam logic [31:0] SSR_RSY_ONES = 32'h0000_0410;
  // Reserved masks that must stay zero
  localparam logic [31:0] SSR_INT_RSVD = 32'hFFC0_0000;
  localparam logic [31:0] SSR_FRAC_RSVD = 32'hF000_0000;
  // Integer divide limits
  localparam logic [15:0] SSR_INT_MIN_45 = 16'h0017;
  localparam logic [15:0] SSR_INT_MAX_45 = 16'h7FFF;
  localparam logic [15:0] SSR_INT_MIN_89 = 16'h004B;
  localparam logic [15:0] SSR_INT_MAX_89 = 16'hFFFF;
  // AXI register byte offsets
  localparam logic [7:0] SSR_OFF_CTRL = 8'h00;
  localparam logic [7:0] SSR_OFF_INT = 8'h04;
  localparam logic [7:0] SSR_OFF_FRAC = 8'h08;
  localparam logic [7:0] SSR_OFF_TMO = 8'h0C;
  localparam logic [7:0] SSR_OFF_ADC = 8'h10;
  localparam logic [7:0] SSR_OFF_RSY = 8'h14;
  localparam logic [7:0] SSR_OFF_CMD = 8'h18;
  localparam logic [7:0] SSR_OFF_STAT = 8'h1C;
  // Command and status bit positions
  localparam int SSR_CMD_UPD_BIT = 8;
  localparam int SSR_ST_BUSY = 0;
  localparam int SSR_ST_RANGE = 1;
  localparam int SSR_ST_CMD = 2;
  // Reset values and AXI response codes
  localparam logic [15:0] SSR_INT_RST = 16'h004B;
  localparam logic [1:0] SSR_RESP_OKAY = 2'b00;
  localparam logic [1:0] SSR_RESP_SLVERR = 2'b10;
  // Serial timing in clock cycles
  localparam int SSR_HALF_CYC = 2;
  localparam int SSR_LE_CYC = 4;
  localparam int SSR_WORD_BITS = 32;
endpackage
`default_nettype wire

/* ssr_shift.sv */
// Serial shifter: sends one 32-bit word MSB first, then pulses latch enable.
// Assumes the device samples data on the rising edge of the serial clock.
`default_nettype none
module ssr_shift #(
  parameter int HALF_CYC = ssr_pkg::SSR_HALF_CYC,
  parameter int LE_CYC = ssr_pkg::SSR_LE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Word request
  input wire logic start,
  input wire logic [31:0] word,
  output logic busy,
  output logic done,
  // Serial pins
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  import ssr_pkg::*;
  typedef enum logic [1:0] {SSR_SH_IDLE, SSR_SH_SHIFT, SSR_SH_LATCH} ssr_sh_t;
  ssr_sh_t state_reg;
  logic [31:0] sh_reg;
  logic [4:0] bit_reg;
  logic [7:0] div_reg;
  logic [5:0] edge_cnt;
  logic ser_clk_d;

  // Frame sequencer: clock divider, bit counter and latch pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= SSR_SH_IDLE;
      sh_reg <= 32'h0000_0000;
      bit_reg <= 5'h00;
      div_reg <= 8'h00;
      ser_clk <= 1'b0;
      ser_data <= 1'b0;
      ser_le <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      unique case (state_reg)
        SSR_SH_IDLE:
        begin
          if (start)
          begin
            sh_reg <= word;
            ser_data <= word[31];
            bit_reg <= 5'h00;
            div_reg <= 8'h00;
            busy <= 1'b1;
            state_reg <= SSR_SH_SHIFT;
          end
        end
        SSR_SH_SHIFT:
        begin
          if (div_reg == 8'(HALF_CYC - 1))
          begin
            div_reg <= 8'h00;
            if (!ser_clk)
              ser_clk <= 1'b1;
            else
            begin
              ser_clk <= 1'b0;
              if (bit_reg == 5'h1F)
                state_reg <= SSR_SH_LATCH;
              else
              begin
                bit_reg <= bit_reg + 5'h01;
                sh_reg <= {sh_reg[30:0], 1'b0};
                ser_data <= sh_reg[30];
              end
            end
          end
          else
            div_reg <= div_reg + 8'h01;
        end
        SSR_SH_LATCH:
        begin
          ser_le <= 1'b1;
          if (div_reg == 8'(LE_CYC - 1))
          begin
            ser_le <= 1'b0;
            div_reg <= 8'h00;
            done <= 1'b1;
            busy <= 1'b0;
            state_reg <= SSR_SH_IDLE;
          end
          else
            div_reg <= div_reg + 8'h01;
        end
      endcase
    end
  end

  // Helper: rising serial clock edges counted within a frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      edge_cnt <= 6'h00;
      ser_clk_d <= 1'b0;
    end
    else
    begin
      ser_clk_d <= ser_clk;
      if (start && !busy)
        edge_cnt <= 6'h00;
      else if (ser_clk && !ser_clk_d)
        edge_cnt <= edge_cnt + 6'h01;
    end
  end

  a_le_after_bits: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    $rose(ser_le) |-> edge_cnt == 6'(SSR_WORD_BITS))
    else $error("Latch pulse before all 32 bits were clocked");
  a_data_stable_high: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
    ser_clk && $past(ser_clk) |-> $stable(ser_data))
    else $error("Serial data changed while serial clock high");
  a_le_clock_low: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
    ser_le |-> !ser_clk)
    else $error("Serial clock high during latch pulse");
endmodule
`default_nettype wire

/* ssr_host.sv */
// Host controller for the synthesizer serial register bank, AXI4-Lite slave.
// Assumes the device latches the shifted word on the latch enable pulse.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none
// What this block does
// R1 - Low four bits select target register
// R2 - Register 0 reserved bits 31:22 sent zero
// R3 - Register 0 write triggers VCO calibration
// R4 - Bit 21 enables calibration, set normally
// R5 - Calibration bit zero keeps current band
// R6 - Clear calibration only when software permits
// R7 - Frequency update forces calibration on
// R8 - Bit 20 selects 4/5 or 8/9 prescaler
// R9 - 4/5 prescaler only below 7 GHz
// R10 - Integer divide value in bits 19:4
// R11 - 4/5 prescaler integer range 23..32767
// R12 - 8/9 prescaler integer range 75..65535
// R13 - Register 1 carries 24-bit fraction numerator
// R14 - Fraction applies at next register 0 write
// R15 - Register 9 holds band divider and timeouts
// R16 - Register 10 ADC fields, bits 23,22 one
// R17 - Register 11 fixed reserved pattern
// R18 - Register 12 resync divider, bits 10,4 one
// R19 - Unknown select code changes nothing
module ssr_host #(
  parameter int HALF_CYC = ssr_pkg::SSR_HALF_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins to the synthesizer
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  import ssr_pkg::*;
  typedef enum logic [1:0] {SSR_M_IDLE, SSR_M_GO, SSR_M_WAIT} ssr_m_t;
  ssr_m_t mst_reg;
  logic pre89_reg;
  logic cal_skip_reg;
  logic [15:0] int_reg;
  logic [23:0] frac_reg;
  logic [27:0] tmo_reg;
  logic [9:0] adc_reg;
  logic [15:0] rsy_reg;
  logic range_err_reg;
  logic cmd_err_reg;
  logic [3:0] last_code_reg;
  logic [15:0] sent_cnt_reg;
  logic [3:0] code_reg;
  logic upd_reg;
  logic second_reg;
  logic [31:0] word_reg;
  logic start_reg;
  logic sh_busy;
  logic sh_done;
  logic [7:0] awaddr_reg;
  logic aw_held;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held;
  logic wr_fire;
  logic cmd_fire;
  logic cmd_ok;
  logic range_set;
  // Byte-lane merge of a write into a stored value
  function automatic logic [31:0] ssr_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction
  // Integer divide value allowed for the chosen prescaler
  function automatic logic ssr_int_ok(input logic p89, input logic [15:0] n);
    if (p89)
      return (n >= SSR_INT_MIN_89) && (n <= SSR_INT_MAX_89); // [R12]
    else
      return (n >= SSR_INT_MIN_45) && (n <= SSR_INT_MAX_45); // [R11]
  endfunction
  // Known select codes of the device
  function automatic logic ssr_code_known(input logic [3:0] c);
    return (c == SSR_CODE_INT) || (c == SSR_CODE_FRAC) || (c == SSR_CODE_TMO) ||
           (c == SSR_CODE_ADC) || (c == SSR_CODE_FIX) || (c == SSR_CODE_RSY);
  endfunction
  // Write address and data are held independently until both arrive
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SSR_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg[7:5] == 3'h0) ? SSR_RESP_OKAY : SSR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Settings registers written by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre89_reg <= 1'b1; // 8/9 default keeps high bands legal [R9]
      cal_skip_reg <= 1'b0;
      int_reg <= SSR_INT_RST;
      frac_reg <= 24'h00_0000;
      tmo_reg <= 28'h000_0000;
      adc_reg <= 10'h000;
      rsy_reg <= 16'h0000;
    end
    else if (wr_fire)
    begin
      unique case (awaddr_reg)
        SSR_OFF_CTRL: {cal_skip_reg, pre89_reg} <=
          2'(ssr_merge({30'h0, cal_skip_reg, pre89_reg}, wdata_reg, wstrb_reg));
        SSR_OFF_INT: int_reg <= 16'(ssr_merge({16'h0, int_reg}, wdata_reg, wstrb_reg));
        SSR_OFF_FRAC: frac_reg <= 24'(ssr_merge({8'h0, frac_reg}, wdata_reg, wstrb_reg));
        SSR_OFF_TMO: tmo_reg <= 28'(ssr_merge({4'h0, tmo_reg}, wdata_reg, wstrb_reg));
        SSR_OFF_ADC: adc_reg <= 10'(ssr_merge({22'h0, adc_reg}, wdata_reg, wstrb_reg));
        SSR_OFF_RSY: rsy_reg <= 16'(ssr_merge({16'h0, rsy_reg}, wdata_reg, wstrb_reg));
        default: ;
      endcase
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SSR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= SSR_RESP_OKAY;
        unique case (s_axi_araddr)
          SSR_OFF_CTRL: s_axi_rdata <= {30'h0, cal_skip_reg, pre89_reg};
          SSR_OFF_INT: s_axi_rdata <= {16'h0, int_reg};
          SSR_OFF_FRAC: s_axi_rdata <= {8'h0, frac_reg};
          SSR_OFF_TMO: s_axi_rdata <= {4'h0, tmo_reg};
          SSR_OFF_ADC: s_axi_rdata <= {22'h0, adc_reg};
          SSR_OFF_RSY: s_axi_rdata <= {16'h0, rsy_reg};
          SSR_OFF_CMD: s_axi_rdata <= 32'h0000_0000;
          SSR_OFF_STAT: s_axi_rdata <= {sent_cnt_reg, 8'h0, last_code_reg, 1'b0,
                                        cmd_err_reg, range_err_reg, mst_reg != SSR_M_IDLE};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SSR_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Command decode: a send is refused while busy or for an unknown code
  assign cmd_fire = wr_fire && (awaddr_reg == SSR_OFF_CMD) && wstrb_reg[0];
  assign cmd_ok = cmd_fire && (mst_reg == SSR_M_IDLE) &&
                  (wdata_reg[SSR_CMD_UPD_BIT] || ssr_code_known(wdata_reg[3:0])); // [R19]
  assign range_set = (mst_reg == SSR_M_GO) && (code_reg == SSR_CODE_INT) &&
                     !ssr_int_ok(pre89_reg, int_reg);
  // Sticky error flags, a hardware set wins over a software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      range_err_reg <= 1'b0;
      cmd_err_reg <= 1'b0;
    end
    else
    begin
      if (range_set)
        range_err_reg <= 1'b1;
      else if (wr_fire && awaddr_reg == SSR_OFF_STAT && wstrb_reg[0] && wdata_reg[SSR_ST_RANGE])
        range_err_reg <= 1'b0;
      if (cmd_fire && !cmd_ok)
        cmd_err_reg <= 1'b1;
      else if (wr_fire && awaddr_reg == SSR_OFF_STAT && wstrb_reg[0] && wdata_reg[SSR_ST_CMD])
        cmd_err_reg <= 1'b0;
    end
  end
  // Word sequencer: builds each device word and hands it to the shifter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mst_reg <= SSR_M_IDLE;
      code_reg <= SSR_CODE_INT;
      upd_reg <= 1'b0;
      second_reg <= 1'b0;
      word_reg <= 32'h0000_0000;
      start_reg <= 1'b0;
      last_code_reg <= 4'h0;
      sent_cnt_reg <= 16'h0000;
    end
    else
    begin
      start_reg <= 1'b0;
      unique case (mst_reg)
        SSR_M_IDLE:
        begin
          if (cmd_ok)
          begin
            upd_reg <= wdata_reg[SSR_CMD_UPD_BIT];
            second_reg <= 1'b0;
            // Update sends the fraction first so it commits with register 0
            code_reg <= wdata_reg[SSR_CMD_UPD_BIT] ? SSR_CODE_FRAC : wdata_reg[3:0]; // [R14]
            mst_reg <= SSR_M_GO;
          end
        end
        SSR_M_GO:
        begin
          if (range_set)
            mst_reg <= SSR_M_IDLE; // Out-of-range divide value is never sent
          else if (!sh_busy) // Never start over a frame still going out
          begin
            unique case (code_reg)
              SSR_CODE_INT: word_reg <= {10'h000, // [R2]
                upd_reg || !cal_skip_reg, // [R3] [R4] [R5] [R6] [R7]
                pre89_reg, int_reg, SSR_CODE_INT}; // [R8] [R10] [R1]
              SSR_CODE_FRAC: word_reg <= {4'h0, frac_reg, SSR_CODE_FRAC}; // [R13]
              SSR_CODE_TMO: word_reg <= {tmo_reg, SSR_CODE_TMO}; // [R15]
              SSR_CODE_ADC: word_reg <= SSR_ADC_ONES | {18'h0, adc_reg, SSR_CODE_ADC}; // [R16]
              SSR_CODE_FIX: word_reg <= SSR_FIX_WORD; // [R17]
              SSR_CODE_RSY: word_reg <= {rsy_reg, 16'h0000} | SSR_RSY_ONES |
                                        {28'h0, SSR_CODE_RSY}; // [R18]
              default: word_reg <= 32'h0000_0000;
            endcase
            start_reg <= 1'b1;
            mst_reg <= SSR_M_WAIT;
          end
        end
        SSR_M_WAIT:
        begin
          if (sh_done)
          begin
            last_code_reg <= code_reg;
            sent_cnt_reg <= sent_cnt_reg + 16'h0001;
            if (upd_reg && !second_reg)
            begin
              second_reg <= 1'b1;
              code_reg <= SSR_CODE_INT;
              mst_reg <= SSR_M_GO;
            end
            else
              mst_reg <= SSR_M_IDLE;
          end
        end
        default: mst_reg <= SSR_M_IDLE;
      endcase
    end
  end

  // Serial shifter for the three-wire link
  ssr_shift #(
    .HALF_CYC(HALF_CYC),
    .LE_CYC(SSR_LE_CYC)
  ) u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_reg),
    .word(word_reg),
    .busy(sh_busy),
    .done(sh_done),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_le(ser_le)
  );
  a_int_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    start_reg && word_reg[3:0] == SSR_CODE_INT |-> (word_reg & SSR_INT_RSVD) == 32'h0)
    else $error("Register 0 word has reserved bits set");
  a_int_range_held: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    start_reg && word_reg[3:0] == SSR_CODE_INT |->
    ssr_int_ok(word_reg[SSR_PRE_BIT], word_reg[19:4]))
    else $error("Integer value out of range for prescaler");
  a_int_range_8_9: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    start_reg && word_reg[3:0] == SSR_CODE_INT && word_reg[SSR_PRE_BIT] |->
    word_reg[19:4] >= SSR_INT_MIN_89)
    else $error("Integer value below 8/9 minimum");
  a_update_cal_on: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    start_reg && upd_reg && word_reg[3:0] == SSR_CODE_INT |-> word_reg[SSR_CAL_BIT])
    else $error("Frequency update sent without calibration");
  a_frac_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    start_reg && word_reg[3:0] == SSR_CODE_FRAC |-> (word_reg & SSR_FRAC_RSVD) == 32'h0)
    else $error("Register 1 word upper bits not zero");
  a_fixed_patterns: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
    start_reg && word_reg[3:0] == SSR_CODE_FIX |-> word_reg == SSR_FIX_WORD)
    else $error("Register 11 word differs from fixed pattern");
  a_adc_ones: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
    start_reg && word_reg[3:0] == SSR_CODE_ADC |->
    word_reg[31:14] == SSR_ADC_ONES[31:14])
    else $error("Register 10 reserved bits wrong");
  a_resync_ones: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
    start_reg && word_reg[3:0] == SSR_CODE_RSY |-> word_reg[15:4] == SSR_RSY_ONES[15:4])
    else $error("Register 12 reserved bits wrong");
  a_frac_then_int: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    sh_done && upd_reg && !second_reg |=> code_reg == SSR_CODE_INT ##1 start_reg)
    else $error("Fraction write not followed by register 0");
  a_bad_code_idle: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
    cmd_fire && !cmd_ok && mst_reg == SSR_M_IDLE |=> mst_reg == SSR_M_IDLE && cmd_err_reg)
    else $error("Unknown code was not refused");
endmodule
`default_nettype wire

/* ssr_dev_model.sv */
// Device model: shifts serial words in and files each by its select code.
// Assumes the serial pins change slowly against aclk.
`default_nettype none
module ssr_dev_model
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // Captured state
  output logic [31:0] reg_word [16],
  output logic [23:0] frac_live,
  output logic [15:0] word_cnt,
  output logic [7:0] cal_cnt,
  output logic len_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_q;
  logic le_q;
  logic [31:0] sh_reg;
  logic [5:0] bit_cnt;
  // Shift on serial clock rise, latch on latch enable rise
  always_ff @(posedge aclk)
  begin
    clk_q <= ser_clk;
    le_q <= ser_le;
    if (!aresetn)
    begin
      bit_cnt <= 6'h00;
      word_cnt <= 16'h0000;
      cal_cnt <= 8'h00;
      len_err <= 1'b0;
      frac_live <= 24'h00_0000;
      for (int i = 0; i < 16; i++) reg_word[i] <= 32'h0000_0000;
    end
    else if (ser_clk && !clk_q)
    begin
      sh_reg <= {sh_reg[30:0], ser_data};
      bit_cnt <= bit_cnt + 6'h01;
    end
    else if (ser_le && !le_q)
    begin
      // Whole word kept, fields in place
      reg_word[sh_reg[3:0]] <= sh_reg;
      word_cnt <= word_cnt + 16'h0001;
      bit_cnt <= 6'h00;
      // A short or long frame is flagged
      if (bit_cnt != 6'h20) len_err <= 1'b1;
      if (sh_reg[3:0] == 4'h0)
      begin
        // Register 0 commits the buffered fraction
        frac_live <= reg_word[1][27:4];
        // Calibration only with its enable set
        if (sh_reg[21]) cal_cnt <= cal_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* ssr_host_tb.sv */
// Bench for the serial register host: AXI4-Lite tasks, device model on the pins.
// Assumes the device model samples the serial pins beside the host.
`default_nettype none
module ssr_host_tb;
  import ssr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, ser_clk, ser_data, ser_le, len_err;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cal_cnt;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] reg_word [16];
  logic [31:0] ew [4];
  logic [3:0] codes [4];
  logic [23:0] frac_live;
  logic [15:0] word_cnt, wc;
  int fails, cmp_count;
  ssr_host #(.HALF_CYC(2)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ser_clk, .ser_data, .ser_le);
  ssr_dev_model dev (.aclk, .aresetn, .ser_clk, .ser_data, .ser_le, .reg_word,
    .frac_live, .word_cnt, .cal_cnt, .len_err);
  // Clock at 20 MHz
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic give_up();
    fails++;
    stop_test();
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 100) give_up();
    check("bresp", {30'h0000_0000, s_axi_bresp}, {30'h0000_0000, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 100) give_up();
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi_rd(a, st, rs);
    check(nm, st, e);
  endtask
  // Command then wait until the frame is out
  task automatic send(input logic [31:0] c);
    int n;
    axi_wr(SSR_OFF_CMD, c, SSR_RESP_OKAY);
    for (n = 0; n < 300; n++)
    begin
      axi_rd(SSR_OFF_STAT, st, rs);
      if (st[SSR_ST_BUSY] === 1'b0) break;
    end
    if (n == 300) give_up();
  endtask
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} <= 6'h3F;
    fails = 0;
    cmp_count = 0;
    codes = '{SSR_CODE_TMO, SSR_CODE_ADC, SSR_CODE_FIX, SSR_CODE_RSY};
    ew = '{{28'h0AB_CDEF, SSR_CODE_TMO}, SSR_ADC_ONES | {18'h0_0000, 10'h2A5, SSR_CODE_ADC},
      SSR_FIX_WORD, {16'hBEEF, 16'h0000} | SSR_RSY_ONES | {28'h000_0000, SSR_CODE_RSY}};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(SSR_OFF_CTRL, 32'h0000_0001, "ctrl");
    rc(SSR_OFF_INT, 32'h0000_004B, "int");
    axi_wr(SSR_OFF_FRAC, 32'h0012_3456, SSR_RESP_OKAY);
    axi_wr(SSR_OFF_INT, 32'h0000_1234, SSR_RESP_OKAY);
    axi_wr(SSR_OFF_TMO, 32'h00AB_CDEF, SSR_RESP_OKAY);
    axi_wr(SSR_OFF_ADC, 32'h0000_02A5, SSR_RESP_OKAY);
    axi_wr(SSR_OFF_RSY, 32'h0000_BEEF, SSR_RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      send({28'h000_0000, codes[k]});
      check("fixed", reg_word[codes[k]], ew[k]);
    end
    send(32'h0000_0001);
    check("reg1", reg_word[1], 32'h0123_4561);
    check("frac held", {8'h00, frac_live}, 32'h0000_0000);
    send(32'h0000_0000);
    check("reg0", reg_word[0], 32'h0031_2340);
    check("frac live", {8'h00, frac_live}, 32'h0012_3456);
    check("cal", {24'h00_0000, cal_cnt}, 32'h0000_0001);
    axi_wr(SSR_OFF_CTRL, 32'h0000_0003, SSR_RESP_OKAY);
    send(32'h0000_0000);
    check("reg0 nocal", reg_word[0], 32'h0011_2340);
    check("cal kept", {24'h00_0000, cal_cnt}, 32'h0000_0001);
    axi_wr(SSR_OFF_FRAC, 32'h0065_4321, SSR_RESP_OKAY);
    send(32'h0000_0100);
    check("upd reg0", reg_word[0], 32'h0031_2340);
    check("upd frac", {8'h00, frac_live}, 32'h0065_4321);
    check("upd cal", {24'h00_0000, cal_cnt}, 32'h0000_0002);
    // Divide limits: below minimum refused, 4/5 minimum and 8/9 maximum sent
    axi_wr(SSR_OFF_CTRL, 32'h0000_0000, SSR_RESP_OKAY);
    axi_wr(SSR_OFF_INT, 32'h0000_0016, SSR_RESP_OKAY);
    wc = word_cnt;
    send(32'h0000_0000);
    check("low 45", st & 32'h0000_0002, 32'h0000_0002);
    check("none 45", {16'h0000, word_cnt}, {16'h0000, wc});
    axi_wr(SSR_OFF_STAT, 32'h0000_0006, SSR_RESP_OKAY);
    axi_wr(SSR_OFF_INT, 32'h0000_0017, SSR_RESP_OKAY);
    send(32'h0000_0000);
    check("int 23", reg_word[0], 32'h0020_0170);
    axi_wr(SSR_OFF_CTRL, 32'h0000_0001, SSR_RESP_OKAY);
    axi_wr(SSR_OFF_INT, 32'h0000_004A, SSR_RESP_OKAY);
    wc = word_cnt;
    send(32'h0000_0000);
    check("low 89", st & 32'h0000_0002, 32'h0000_0002);
    check("none 89", {16'h0000, word_cnt}, {16'h0000, wc});
    axi_wr(SSR_OFF_STAT, 32'h0000_0006, SSR_RESP_OKAY);
    axi_wr(SSR_OFF_INT, 32'h0000_FFFF, SSR_RESP_OKAY);
    send(32'h0000_0000);
    check("int max", reg_word[0], 32'h003F_FFF0);
    // Only the strobed byte lane of a setting changes
    s_axi_wstrb <= 4'h1;
    axi_wr(SSR_OFF_INT, 32'h0000_0012, SSR_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rc(SSR_OFF_INT, 32'h0000_FF12, "int lane");
    // A command while a frame is going out is refused
    wc = word_cnt;
    axi_wr(SSR_OFF_CMD, 32'h0000_0009, SSR_RESP_OKAY);
    send(32'h0000_0009);
    check("busy cmd", st & 32'h0000_0004, 32'h0000_0004);
    check("one word", {16'h0000, word_cnt}, {16'h0000, wc + 16'h0001});
    axi_wr(SSR_OFF_STAT, 32'h0000_0006, SSR_RESP_OKAY);
    // Unknown code and unmapped offset change nothing
    wc = word_cnt;
    send(32'h0000_0005);
    check("bad code", st & 32'h0000_0004, 32'h0000_0004);
    check("none bad", {16'h0000, word_cnt}, {16'h0000, wc});
    axi_wr(8'h20, 32'h0000_0001, SSR_RESP_SLVERR);
    axi_rd(8'h20, st, rs);
    check("unmapped", st, 32'h0000_0000);
    check("unm resp", {30'h0000_0000, rs}, {30'h0000_0000, SSR_RESP_SLVERR});
    axi_rd(SSR_OFF_STAT, st, rs);
    check("words", {16'h0000, st[31:16]}, {16'h0000, word_cnt});
    check("frame len", {31'h0000_0000, len_err}, 32'h0000_0000);
    stop_test();
  end
endmodule
`default_nettype wire
